// File: rtl/redriver_link_map.svh
// Offsets-free constant map: timing figures and cycle counts for the link controller
`ifndef REDRIVER_LINK_MAP_SVH
`define REDRIVER_LINK_MAP_SVH
`define CLK_PERIOD_NS 50
`define RETRY_INTERVAL_NS 12000000
`define RETRY_CYCLES (`RETRY_INTERVAL_NS / `CLK_PERIOD_NS)
`define SLEEP_ENTRY_NS 2000
`define SLEEP_ENTRY_CYCLES (`SLEEP_ENTRY_NS / `CLK_PERIOD_NS)
`define SLEEP_EXIT_NS 100000
`define SLEEP_EXIT_CYCLES (`SLEEP_EXIT_NS / `CLK_PERIOD_NS)
`define U23_IDLE_CYCLES 32'd4000
`define U23_DETECT_CYCLES 32'd240000
`define DETECT_SETTLE_CYCLES 32'd4
`endif

// File: rtl/redriver_link_pkg.sv
// Types shared by the link controller
package redriver_link_pkg;
  typedef enum logic [2:0] {
    ST_SLEEP, ST_WAKE, ST_DET_PREP, ST_DET_SENSE, ST_DET_WAIT, ST_ACTIVE, ST_U23, ST_U23_SENSE
  } link_state_e;
  typedef struct packed {
    logic [1:0] rx_term_on;
    logic [1:0] tx_term_on;
    logic [1:0] tx_idle;
    logic [1:0] forward;
  } chan_ctrl_s;
endpackage

// File: rtl/redriver_link_ctrl.sv
// Link power and receiver-detect controller for a two-channel redriver
`timescale 1ns/1ps
`default_nettype none
`include "redriver_link_map.svh"

// Behaviour
// R1 - Idle timers recognise U2/U3, power down
// R2 - LFPS activity in U2/U3 wakes device
// R3 - Power-up or enable toggle runs detect
// R4 - Both receivers found: terminations go active
// R5 - Missing receiver: transmitter Hi-Z, low power
// R6 - Retry detection every 12 ms until found
// R7 - Detect periodically while in U2/U3
// R8 - U2/U3 detect keeps input termination on
// R9 - U2/U3 detect fail restarts power-up detect
// R10 - Per channel idle below LFPS threshold
// R11 - Idle input drives transmitter idle
// R12 - Above threshold input forwards again
// R13 - Idle entry and exit within 6 ns; here one registered 50 ns clock cycle later
// R14 - Enable low puts device in sleep
// R15 - Sleep entry 2 us, exit 100 us
// R16 - No receiver: detect mode, inputs Hi-Z
// R17 - U2/U3 idle duration is a parameter
module redriver_link_ctrl
  import redriver_link_pkg::*;
#(
  parameter int RETRY_CYCLES = `RETRY_CYCLES,
  parameter int SLEEP_EXIT_CYCLES = `SLEEP_EXIT_CYCLES,
  parameter int U23_IDLE_CYCLES = `U23_IDLE_CYCLES,
  parameter int U23_DETECT_CYCLES = `U23_DETECT_CYCLES,
  parameter int SETTLE_CYCLES = `DETECT_SETTLE_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_link_en,
  input wire logic [1:0] i_rx_above_lfps,
  input wire logic [1:0] i_rx_below_lfps,
  input wire logic [1:0] i_far_rx_present,
  output logic o_detect_pulse,
  output logic [1:0] o_rx_term_on,
  output logic [1:0] o_tx_term_on,
  output logic [1:0] o_tx_idle,
  output logic [1:0] o_forward,
  output logic o_low_power,
  output logic o_sleep
);

  localparam int CW = 32;

  link_state_e state_r, state_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic [CW-1:0] idle_cnt_r, idle_cnt_nxt;
  logic en_q_r, en_q_nxt;
  logic first_r, first_nxt;
  logic [1:0] idle_r, idle_nxt;
  chan_ctrl_s ctl_r, ctl_nxt;
  logic pulse_r, pulse_nxt;
  logic lowp_r, lowp_nxt;
  logic sleep_r, sleep_nxt;

  // Per channel idle tracking with hysteresis between the two thresholds
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_idle
      always_comb begin
        idle_nxt[g] = idle_r[g];
        if (i_rx_below_lfps[g]) begin
          idle_nxt[g] = 1'b1; // R10
        end else if (i_rx_above_lfps[g]) begin
          idle_nxt[g] = 1'b0; // R12
        end
      end
    end
  endgenerate

  // Link state sequencing and termination control
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    idle_cnt_nxt = idle_cnt_r;
    en_q_nxt = i_link_en;
    first_nxt = 1'b0;
    ctl_nxt = ctl_r;
    pulse_nxt = 1'b0;
    lowp_nxt = lowp_r;
    sleep_nxt = sleep_r;
    // Idle forwarding per channel, only while the channel is live
    ctl_nxt.tx_idle = idle_nxt | ~ctl_r.tx_term_on; // R11 R13
    ctl_nxt.forward = ~idle_nxt & ctl_r.tx_term_on; // R12 R13
    // All-idle timer for U2/U3 recognition
    if (&idle_r) begin
      if (idle_cnt_r < CW'(U23_IDLE_CYCLES)) begin
        idle_cnt_nxt = idle_cnt_r + 1'b1;
      end
    end else begin
      idle_cnt_nxt = '0;
    end
    case (state_r)
      ST_SLEEP: begin
        ctl_nxt.rx_term_on = 2'b00; // R14
        ctl_nxt.tx_term_on = 2'b00;
        ctl_nxt.forward = 2'b00;
        ctl_nxt.tx_idle = 2'b11;
        sleep_nxt = 1'b1;
        lowp_nxt = 1'b1;
        if (i_link_en && !en_q_r) begin
          state_nxt = ST_WAKE; // R15
          cnt_nxt = '0;
        end
      end
      ST_WAKE: begin
        if (cnt_r >= CW'(SLEEP_EXIT_CYCLES - 1)) begin
          sleep_nxt = 1'b0;
          state_nxt = ST_DET_PREP; // R15 R3
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_DET_PREP: begin
        ctl_nxt.rx_term_on = 2'b00; // R3 R16
        ctl_nxt.tx_term_on = 2'b00;
        lowp_nxt = 1'b1;
        sleep_nxt = 1'b0; // R3
        pulse_nxt = 1'b1;
        state_nxt = ST_DET_SENSE;
        cnt_nxt = '0;
      end
      ST_DET_SENSE: begin
        if (cnt_r >= CW'(SETTLE_CYCLES - 1)) begin
          if (&i_far_rx_present) begin // R3
            ctl_nxt.rx_term_on = 2'b11; // R4
            ctl_nxt.tx_term_on = 2'b11;
            lowp_nxt = 1'b0;
            state_nxt = ST_ACTIVE;
          end else begin
            ctl_nxt.tx_term_on = 2'b00; // R5
            lowp_nxt = 1'b1;
            state_nxt = ST_DET_WAIT;
          end
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_DET_WAIT: begin
        if (cnt_r >= CW'(RETRY_CYCLES - 1)) begin
          state_nxt = ST_DET_PREP; // R6
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_ACTIVE: begin
        if (idle_cnt_r >= CW'(U23_IDLE_CYCLES)) begin
          state_nxt = ST_U23; // R1 R17
          lowp_nxt = 1'b1;
          cnt_nxt = '0;
        end
      end
      ST_U23: begin
        if (!(&idle_r)) begin
          state_nxt = ST_ACTIVE; // R2
          lowp_nxt = 1'b0;
          idle_cnt_nxt = '0;
        end else if (cnt_r >= CW'(U23_DETECT_CYCLES - 1)) begin
          state_nxt = ST_U23_SENSE; // R7 R8
          pulse_nxt = 1'b1;
          cnt_nxt = '0;
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      ST_U23_SENSE: begin
        if (cnt_r >= CW'(SETTLE_CYCLES - 1)) begin
          cnt_nxt = '0;
          if (&i_far_rx_present) begin
            state_nxt = ST_U23; // R9
          end else begin
            ctl_nxt.rx_term_on = 2'b00; // R9
            ctl_nxt.tx_term_on = 2'b00;
            state_nxt = ST_DET_PREP;
          end
        end else begin
          cnt_nxt = cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt = ST_SLEEP;
      end
    endcase
    // Falling enable or low enable forces sleep, within one cycle
    if (!i_link_en && state_r != ST_SLEEP) begin
      state_nxt = ST_SLEEP; // R14 R6 R15
      cnt_nxt = '0;
    end
    // Start after reset: detect if enabled, else sleep
    if (first_r) begin
      state_nxt = i_link_en ? ST_DET_PREP : ST_SLEEP; // R3 R14
    end
  end

  // State registers
  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= ST_SLEEP;
      cnt_r <= '0;
      idle_cnt_r <= '0;
      en_q_r <= 1'b0;
      first_r <= 1'b1;
      idle_r <= 2'b11;
      ctl_r <= '{rx_term_on: 2'b00, tx_term_on: 2'b00, tx_idle: 2'b11, forward: 2'b00};
      pulse_r <= 1'b0;
      lowp_r <= 1'b1;
      sleep_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      idle_cnt_r <= idle_cnt_nxt;
      en_q_r <= en_q_nxt;
      first_r <= first_nxt;
      idle_r <= idle_nxt;
      ctl_r <= ctl_nxt;
      pulse_r <= pulse_nxt;
      lowp_r <= lowp_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // Outputs straight from flops
  assign o_detect_pulse = pulse_r;
  assign o_rx_term_on = ctl_r.rx_term_on;
  assign o_tx_term_on = ctl_r.tx_term_on;
  assign o_tx_idle = ctl_r.tx_idle;
  assign o_forward = ctl_r.forward;
  assign o_low_power = lowp_r;
  assign o_sleep = sleep_r;

endmodule
`default_nettype wire

// File: tb/redriver_link_properties.sv
// Port assertions for the link controller
`timescale 1ns/1ps
`default_nettype none
module redriver_link_properties #(
  parameter int RETRY_CYCLES = 20,
  parameter int SETTLE_CYCLES = 4
) (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic i_link_en,
  input wire logic [1:0] i_rx_above_lfps,
  input wire logic [1:0] i_rx_below_lfps,
  input wire logic [1:0] i_far_rx_present,
  input wire logic o_detect_pulse,
  input wire logic [1:0] o_rx_term_on,
  input wire logic [1:0] o_tx_term_on,
  input wire logic [1:0] o_tx_idle,
  input wire logic [1:0] o_forward,
  input wire logic o_low_power,
  input wire logic o_sleep
);
  localparam int GAP = RETRY_CYCLES + SETTLE_CYCLES - 3;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  // Detect attempt and the far-end answer over the sense time
  sequence s_found;
    o_detect_pulse ##1 (i_link_en && i_far_rx_present == 2'b11) [*4];
  endsequence
  sequence s_miss;
    o_detect_pulse ##1 (i_link_en && i_far_rx_present != 2'b11) [*4];
  endsequence
  a_found_terms_on:
  assert property (s_found |-> ##[0:2] (o_tx_term_on & o_rx_term_on) == 2'b11) else $error("terms");
  a_miss_terms_off:
  assert property (s_miss |-> ##1 (o_low_power && {o_tx_term_on, o_rx_term_on} == 4'h0) [*2])
    else $error("miss");
  a_retry_gap_exact:
  assert property (o_rx_term_on == 2'b00 ##0 s_miss |-> ##GAP (o_detect_pulse || !i_link_en))
    else $error("retry");
  a_sleep_on_fall:
  assert property ($fell(i_link_en) ##1 !i_link_en |=> o_sleep && o_rx_term_on == 2'b00)
    else $error("sleep");
  a_u23_entry_idle:
  assert property ((!o_low_power && i_link_en && i_rx_below_lfps == 2'b11) [*8] |->
    ##[1:8] (o_low_power || i_rx_below_lfps != 2'b11)) else $error("u23");
  a_lfps_wake_up:
  assert property ((o_low_power && !o_sleep && o_rx_term_on == 2'b11 && i_link_en
    && i_rx_above_lfps != 2'b00) [*2] |-> ##[1:3] !o_low_power) else $error("wake");
  a_idle_entry_ch:
  assert property ((!o_low_power && i_link_en && i_rx_below_lfps[0]) [*3] |=>
    o_tx_idle[0] && !o_forward[0]) else $error("idle");
  a_idle_exit_ch:
  assert property ((!o_low_power && i_link_en && i_rx_above_lfps[1]) [*3] |=>
    o_forward[1] && !o_tx_idle[1]) else $error("fwd");
  a_awake_when_active:
  assert property (!o_low_power |-> !o_sleep && o_rx_term_on == 2'b11) else $error("awake");
endmodule
bind redriver_link_ctrl redriver_link_properties #(.RETRY_CYCLES(RETRY_CYCLES),
  .SETTLE_CYCLES(SETTLE_CYCLES)) redriver_link_properties_inst (.i_clock(i_clock),
  .i_sys_rst(i_sys_rst), .i_link_en(i_link_en), .i_rx_above_lfps(i_rx_above_lfps),
  .i_rx_below_lfps(i_rx_below_lfps), .i_far_rx_present(i_far_rx_present),
  .o_detect_pulse(o_detect_pulse), .o_rx_term_on(o_rx_term_on), .o_tx_term_on(o_tx_term_on),
  .o_tx_idle(o_tx_idle), .o_forward(o_forward), .o_low_power(o_low_power), .o_sleep(o_sleep));
`default_nettype wire

// File: tb/far_end_model.sv
// Far port model: receiver termination and line activity
`timescale 1ns/1ps
`default_nettype none
module far_end_model (
  input wire logic i_clock,
  input wire logic i_detect_pulse,
  input wire logic [1:0] i_attached,
  input wire logic [1:0] i_active,
  output logic [1:0] o_far_rx_present,
  output logic [1:0] o_rx_above_lfps,
  output logic [1:0] o_rx_below_lfps
);
  logic [2:0] win_r = 3'h0;
  logic [1:0] junk_r = 2'h1;
  // Sense answer only near a detect pulse, churn outside it
  always @(posedge i_clock) begin
    win_r <= i_detect_pulse ? 3'h6 : win_r - 3'(win_r != 3'h0);
    junk_r <= ~junk_r;
  end
  assign o_far_rx_present = (i_detect_pulse || win_r != 3'h0) ? i_attached : junk_r;
  assign o_rx_above_lfps = i_active;
  assign o_rx_below_lfps = ~i_active;
endmodule
`default_nettype wire

// File: tb/redriver_link_ctrl_tb.sv
// Self-checking bench for the link controller
`timescale 1ns/1ps
`default_nettype none
module redriver_link_ctrl_tb;
  import redriver_link_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_link_en = 1'b1;
  logic [1:0] attached = 2'b11;
  logic [1:0] active = 2'b11;
  logic [1:0] above, below, far;
  logic pulse, low_power, sleep;
  wire chan_ctrl_s ctl;
  logic [9:0] notes[$];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int ch;
  event ev;
  always #25 i_clock = ~i_clock;
  redriver_link_ctrl #(.RETRY_CYCLES(20), .SLEEP_EXIT_CYCLES(5), .U23_IDLE_CYCLES(8),
    .U23_DETECT_CYCLES(30), .SETTLE_CYCLES(4)) redriver_link_ctrl_inst (.i_clock(i_clock),
    .i_sys_rst(i_sys_rst), .i_link_en(i_link_en), .i_rx_above_lfps(above),
    .i_rx_below_lfps(below), .i_far_rx_present(far), .o_detect_pulse(pulse),
    .o_rx_term_on(ctl.rx_term_on), .o_tx_term_on(ctl.tx_term_on), .o_tx_idle(ctl.tx_idle),
    .o_forward(ctl.forward), .o_low_power(low_power), .o_sleep(sleep));
  far_end_model far_end_model_inst (.i_clock(i_clock), .i_detect_pulse(pulse),
    .i_attached(attached), .i_active(active), .o_far_rx_present(far),
    .o_rx_above_lfps(above), .o_rx_below_lfps(below));
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
    #5;
  endtask
  task automatic check_status(input logic [9:0] exp, input logic [9:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Watcher compares each status with the oldest note
  always @(ev) check_status(notes.pop_front(), {sleep, low_power, ctl});
  task automatic expect_st(input logic [9:0] v);
    notes.push_back(v);
    -> ev;
  endtask
  task automatic wait_pulse();
    int k;
    k = 0;
    while (pulse !== 1'b1 && k < 60) begin
      tick(1);
      k++;
    end
    if (k == 60) n_errors++;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 2000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    ch = $urandom(32'h6519_665e);
    tick(2);
    expect_st(10'h30c);
    i_sys_rst = 1'b0;
    wait_pulse();
    tick(8);
    expect_st(10'h0f3);
    ch = $urandom % 2;
    active[ch] = 1'b0;
    tick(4);
    expect_st(10'h0f3 ^ (10'h005 << ch));
    active[ch] = 1'b1;
    tick(4);
    expect_st(10'h0f3);
    $display("detect and idle done");
    active = 2'b00;
    tick(20);
    expect_st(10'h1fc);
    wait_pulse();
    expect_st(10'h1fc);
    tick(8);
    expect_st(10'h1fc);
    active[ch] = 1'b1;
    tick(6);
    expect_st(10'h0f3 ^ (10'h005 << (1 - ch)));
    active = 2'b00;
    tick(20);
    attached = 2'b00;
    wait_pulse();
    tick(8);
    expect_st(10'h10c);
    wait_pulse();
    tick(1);
    wait_pulse();
    $display("low power done");
    i_link_en = 1'b0;
    tick(3);
    expect_st(10'h30c);
    attached = 2'b11;
    active = 2'b11;
    i_link_en = 1'b1;
    wait_pulse();
    tick(8);
    expect_st(10'h0f3);
    $display("sleep done");
    give_verdict();
  end
endmodule
`default_nettype wire
